// [src/pfs_pin_function_select.sv]
// Purpose: Per-pin function selection registers for P0.7 to P2.2, with pin interrupt edges.
// Assumes: Classic Wishbone slave, 32-bit data, byte address is four times the word index.
// Notes:   Each register is the low byte of its word; upper bits read as zero.
//
// The implementer's own choice: the Wishbone interface to the registers.
module pfs_pin_function_select #(
    parameter int ADR_WIDTH = 18
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Wishbone slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [ADR_WIDTH-1:0]   adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    // Pad levels of the pin interrupt pins
    input  wire logic                   pin16_level_i,
    input  wire logic                   pin17_level_i,
    // Routing enables and interrupt pulses
    output pfs_pkg::pfs_route_s         route_o,
    output logic                        pin_irq_group0_line0_o,
    output logic                        pin_irq_group0_line1_o
);

    logic [7:0]  sel_reg [pfs_pkg::PFS_NUM_REGS];
    logic        req;
    logic        hit;
    logic [3:0]  hit_slot;
    logic [15:0] word_idx;
    logic [1:0]  pin_meta;
    logic [1:0]  pin_sync;
    logic [1:0]  pin_prev;
    logic [1:0]  next_irq;

    assign req      = cyc_i && stb_i && !ack_o;
    assign word_idx = 16'(adr_i[ADR_WIDTH-1:2]);

    always_comb begin
        hit      = 1'b0;
        hit_slot = 4'h0;
        for (int i = 0; i < pfs_pkg::PFS_NUM_REGS; i++) begin
            if (word_idx == pfs_pkg::PFS_IDX[i]) begin
                hit      = 1'b1;
                hit_slot = 4'(i);
            end
        end
    end

    // Ack comes one cycle after the request and drops the cycle after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < pfs_pkg::PFS_NUM_REGS; i++) begin
                sel_reg[i] <= pfs_pkg::PFS_RESET_VAL;
            end
        end else if (req && we_i && sel_i[0] && hit) begin
            sel_reg[hit_slot] <= dat_i[7:0] & pfs_pkg::PFS_MASK[hit_slot];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i && hit) begin
            dat_o <= {24'h00_0000, sel_reg[hit_slot]};
        end else if (req) begin
            dat_o <= 32'h0000_0000;
        end
    end

    assign route_o.adc_d2_select           = sel_reg[pfs_pkg::PFS_S_P07][pfs_pkg::PFS_B_ALT2];
    assign route_o.uart0_receive_select    = sel_reg[pfs_pkg::PFS_S_P07][pfs_pkg::PFS_B_ALT1];
    assign route_o.pca0_signal_select      = sel_reg[pfs_pkg::PFS_S_P10][pfs_pkg::PFS_B_ALT2];
    assign route_o.adc_d3_select           = sel_reg[pfs_pkg::PFS_S_P10][pfs_pkg::PFS_B_ALT1];
    assign route_o.pca1_signal_select      = sel_reg[pfs_pkg::PFS_S_P11][pfs_pkg::PFS_B_ALT2];
    assign route_o.adc_d4_select           = sel_reg[pfs_pkg::PFS_S_P11][pfs_pkg::PFS_B_ALT1];
    assign route_o.i2c_master_data_select  = sel_reg[pfs_pkg::PFS_S_P12][pfs_pkg::PFS_B_ALT2];
    assign route_o.i2c_slave_data_select   = sel_reg[pfs_pkg::PFS_S_P12][pfs_pkg::PFS_B_ALT1];
    assign route_o.i2c_master_clock_select = sel_reg[pfs_pkg::PFS_S_P13][pfs_pkg::PFS_B_ALT2];
    assign route_o.i2c_slave_clock_select  = sel_reg[pfs_pkg::PFS_S_P13][pfs_pkg::PFS_B_ALT1];
    assign route_o.timer1_input_select =
        sel_reg[pfs_pkg::PFS_S_P16][pfs_pkg::PFS_B_TIMER_INPUT];
    assign route_o.timer0_input_select =
        sel_reg[pfs_pkg::PFS_S_P17][pfs_pkg::PFS_B_TIMER_INPUT];
    assign route_o.pin_irq_line0_select    = sel_reg[pfs_pkg::PFS_S_P16][pfs_pkg::PFS_B_ALT1];
    assign route_o.pin_irq_line1_select    = sel_reg[pfs_pkg::PFS_S_P17][pfs_pkg::PFS_B_ALT1];
    assign route_o.crystal_input_select    = sel_reg[pfs_pkg::PFS_S_P20][pfs_pkg::PFS_B_ALT1];
    assign route_o.crystal_output_select   = sel_reg[pfs_pkg::PFS_S_P21][pfs_pkg::PFS_B_ALT1];
    assign route_o.uart2_transmit_select   = sel_reg[pfs_pkg::PFS_S_P22][pfs_pkg::PFS_B_ALT1];

    for (genvar g = 0; g < pfs_pkg::PFS_NUM_REGS; g++) begin : g_gpio
        assign route_o.general_io_enable[g] = sel_reg[g][pfs_pkg::PFS_B_GENERAL_IO];
    end

    // Pad levels pass two flip-flops before the edge detector sees them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 2'b00;
            pin_sync <= 2'b00;
            pin_prev <= 2'b00;
        end else begin
            pin_meta <= {pin17_level_i, pin16_level_i};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    always_comb begin
        next_irq = 2'b00;
        for (int k = 0; k < 2; k++) begin
            if (sel_reg[pfs_pkg::PFS_S_P16 + k][pfs_pkg::PFS_B_ALT1]) begin
                if (sel_reg[pfs_pkg::PFS_S_P16 + k][pfs_pkg::PFS_B_ALT2]) begin
                    next_irq[k] = pin_sync[k] && !pin_prev[k];
                end else begin
                    next_irq[k] = !pin_sync[k] && pin_prev[k];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_irq_group0_line0_o <= 1'b0;
            pin_irq_group0_line1_o <= 1'b0;
        end else begin
            pin_irq_group0_line0_o <= next_irq[0];
            pin_irq_group0_line1_o <= next_irq[1];
        end
    end

endmodule : pfs_pin_function_select

// [src/pfs_pkg.sv]
// Purpose: Constants and types for the pin function select block.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes:   Register slot order is P0.7, P1.0 to P1.7, P2.0, P2.1, P2.2.
package pfs_pkg;

    localparam int          PFS_NUM_REGS   = 12;
    localparam int          PFS_IDX_WIDTH  = 16;
    localparam logic [7:0]  PFS_RESET_VAL  = 8'h00;

    // Word indices of the selection registers.
    localparam logic [15:0] PFS_IDX_P07 = 16'hA057;
    localparam logic [15:0] PFS_IDX_P10 = 16'hA058;
    localparam logic [15:0] PFS_IDX_P11 = 16'hA059;
    localparam logic [15:0] PFS_IDX_P12 = 16'hA05A;
    localparam logic [15:0] PFS_IDX_P13 = 16'hA05B;
    localparam logic [15:0] PFS_IDX_P14 = 16'hA05C;
    localparam logic [15:0] PFS_IDX_P15 = 16'hA05D;
    localparam logic [15:0] PFS_IDX_P16 = 16'hA05E;
    localparam logic [15:0] PFS_IDX_P17 = 16'hA05F;
    localparam logic [15:0] PFS_IDX_P20 = 16'hA070;
    localparam logic [15:0] PFS_IDX_P21 = 16'hA071;
    localparam logic [15:0] PFS_IDX_P22 = 16'hA072;

    localparam logic [15:0] PFS_IDX [PFS_NUM_REGS] = '{
        PFS_IDX_P07, PFS_IDX_P10, PFS_IDX_P11, PFS_IDX_P12,
        PFS_IDX_P13, PFS_IDX_P14, PFS_IDX_P15, PFS_IDX_P16,
        PFS_IDX_P17, PFS_IDX_P20, PFS_IDX_P21, PFS_IDX_P22
    };

    // Implemented bits of each register, same slot order.
    localparam logic [7:0]  PFS_MASK [PFS_NUM_REGS] = '{
        8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h01,
        8'h01, 8'h0F, 8'h0F, 8'h03, 8'h03, 8'h03
    };

    // Slot numbers.
    localparam int PFS_S_P07 = 0;
    localparam int PFS_S_P10 = 1;
    localparam int PFS_S_P11 = 2;
    localparam int PFS_S_P12 = 3;
    localparam int PFS_S_P13 = 4;
    localparam int PFS_S_P14 = 5;
    localparam int PFS_S_P15 = 6;
    localparam int PFS_S_P16 = 7;
    localparam int PFS_S_P17 = 8;
    localparam int PFS_S_P20 = 9;
    localparam int PFS_S_P21 = 10;
    localparam int PFS_S_P22 = 11;

    // Field positions.
    localparam int PFS_B_GENERAL_IO  = 0;
    localparam int PFS_B_ALT1        = 1;
    localparam int PFS_B_ALT2        = 2;
    localparam int PFS_B_TIMER_INPUT = 3;

    // Routing enables towards peripherals and pad drivers.
    typedef struct packed {
        logic        adc_d2_select;
        logic        uart0_receive_select;
        logic        pca0_signal_select;
        logic        adc_d3_select;
        logic        pca1_signal_select;
        logic        adc_d4_select;
        logic        i2c_master_data_select;
        logic        i2c_slave_data_select;
        logic        i2c_master_clock_select;
        logic        i2c_slave_clock_select;
        logic        timer1_input_select;
        logic        timer0_input_select;
        logic        pin_irq_line0_select;
        logic        pin_irq_line1_select;
        logic        crystal_input_select;
        logic        crystal_output_select;
        logic        uart2_transmit_select;
        logic [11:0] general_io_enable;
    } pfs_route_s;

endpackage : pfs_pkg

// [sim/pfs_monitor.sv]
// Purpose: Bus and pin interrupt checks for the pin function select block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   An interrupt pulse must follow a pad change by three to five cycles.
module pfs_monitor (
    // Clock, reset and bus
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               cyc_i,
    input wire logic               stb_i,
    input wire logic               we_i,
    input wire logic [31:0]        dat_o,
    input wire logic               ack_o,
    // Pads, routing and pulses
    input wire logic               pin16_level_i,
    input wire logic               pin17_level_i,
    input wire pfs_pkg::pfs_route_s route_o,
    input wire logic               pin_irq_group0_line0_o,
    input wire logic               pin_irq_group0_line1_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s; cyc_i && stb_i && !ack_o; endsequence
    sequence moved16_s; $past(pin16_level_i, 3) != $past(pin16_level_i, 6); endsequence
    sequence moved17_s; $past(pin17_level_i, 3) != $past(pin17_level_i, 6); endsequence
    ack_req_a: assert property (req_s |=> ack_o) else $error("ack missing");
    ack_one_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
    ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    upper_zero_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    route_hold_a: assert property (!(cyc_i && stb_i && we_i && !ack_o) |=> $stable(route_o))
        else $error("route changed without write");
    irq_single_a: assert property (pin_irq_group0_line0_o |=> !pin_irq_group0_line0_o)
        else $error("irq0 pulse too long");
    irq0_enable_a: assert property (pin_irq_group0_line0_o |-> $past(route_o.pin_irq_line0_select))
        else $error("irq0 while disabled");
    irq1_enable_a: assert property (pin_irq_group0_line1_o |-> $past(route_o.pin_irq_line1_select))
        else $error("irq1 while disabled");
    irq0_cause_a: assert property (pin_irq_group0_line0_o |-> moved16_s)
        else $error("irq0 without pad edge");
    irq1_cause_a: assert property (pin_irq_group0_line1_o |-> moved17_s)
        else $error("irq1 without pad edge");
endmodule : pfs_monitor

// [sim/test_pfs_pin_function_select.sv]
// Purpose: Self-checking bench for the pin function select block.
// Assumes: Wishbone single cycles, one register per word.
// Notes:   Route expectations come from a shadow copy of every register.
module test_pfs_pin_function_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, p16 = 0, p17 = 0;
    logic [17:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat = '0, dat_o;
    logic ack_o, irq0, irq1;
    pfs_pkg::pfs_route_s route_o;
    logic [7:0] sh [12], q [$], rnd = 8'h14, d;
    logic [7:0] m [12] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h01,
                           8'h01, 8'h0F, 8'h0F, 8'h03, 8'h03, 8'h03};
    int mismatches = 0, cmp_count = 0, c0 = 0, c1 = 0;
    always #5 clk_i = ~clk_i;
    pfs_pin_function_select DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .pin16_level_i(p16), .pin17_level_i(p17), .route_o(route_o),
        .pin_irq_group0_line0_o(irq0), .pin_irq_group0_line1_o(irq1));
    function automatic logic [7:0] nxt(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : nxt
    function automatic logic [28:0] exp_route();
        logic [28:0] e;
        e = '0;
        for (int s = 0; s < 12; s++) e[s] = sh[s][0];
        for (int s = 0; s < 5; s++) begin
            e[28-2*s] = sh[s][2];
            e[27-2*s] = sh[s][1];
        end
        e[18:12] = {sh[7][3], sh[8][3], sh[7][1], sh[8][1], sh[9][1], sh[10][1], sh[11][1]};
        return e;
    endfunction : exp_route
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        cmp_count++;
        if (seen !== ex) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d,
                       input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {ix, 2'h0};
        dat <= {24'hFFFFFF, d};
        sel <= s;
        do @(posedge clk_i); while (ack_o !== 1'h1);
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : bus
    task automatic wr(input int s, input logic [7:0] d, input logic [3:0] se);
        bus(1'h1, pfs_pkg::PFS_IDX[s], d, se);
        if (se[0]) sh[s] = d & m[s];
        @(negedge clk_i);
        chk("route", {3'h0, route_o}, {3'h0, exp_route()});
    endtask : wr
    task automatic rd(input logic [15:0] ix, input logic [7:0] ex);
        q.push_back(ex);
        bus(1'h0, ix, 8'h00, 4'hF);
    endtask : rd
    task automatic pads(input logic a, input logic b);
        @(posedge clk_i);
        p16 <= a;
        p17 <= b;
        repeat (8) @(posedge clk_i);
    endtask : pads
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i) begin
        if (ack_o === 1'h1 && we === 1'h0 && q.size() > 0) begin
            chk("read", dat_o, {24'h0, q.pop_front()});
        end
        if (irq0 === 1'h1) c0++;
        if (irq1 === 1'h1) c1++;
    end
    initial begin
        foreach (sh[s]) sh[s] = 8'h00;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        @(negedge clk_i);
        chk("route", {3'h0, route_o}, 32'h0);
        for (int s = 0; s < 12; s++) rd(pfs_pkg::PFS_IDX[s], 8'h00);
        // IO config lives outside this block; nothing to drive here.
        for (int k = 0; k < 48; k++) begin
            rnd = nxt(rnd);
            // At most one enable per write; edge bit and unused bits vary.
            d = ((8'h01 << rnd[1:0]) & m[k % 12]) | (rnd & 8'hF0);
            if (k % 12 == 7 || k % 12 == 8) d = d | {5'h00, rnd[2], 2'h0};
            wr(k % 12, d, 4'h1);
            rd(pfs_pkg::PFS_IDX[k % 12], sh[k % 12]);
        end
        // A write without the low byte select and an unmapped write change nothing.
        wr(0, 8'h04, 4'hE);
        bus(1'h1, 16'hA060, 8'hFF, 4'hF);
        rd(16'hA060, 8'h00);
        rd(pfs_pkg::PFS_IDX[0], sh[0]);
        for (int s = 0; s < 12; s++) wr(s, 8'h00, 4'h1);
        wr(7, 8'h02, 4'h1);
        wr(8, 8'h06, 4'h1);
        pads(1, 1);
        pads(0, 0);
        chk("irq0", c0, 1);
        chk("irq1", c1, 1);
        wr(7, 8'h06, 4'h1);
        wr(8, 8'h04, 4'h1);
        pads(1, 1);
        pads(0, 0);
        chk("irq0", c0, 2);
        chk("irq1", c1, 1);
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
endmodule : test_pfs_pin_function_select
bind pfs_pin_function_select pfs_monitor MON (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .pin16_level_i(pin16_level_i),
    .pin17_level_i(pin17_level_i), .route_o(route_o),
    .pin_irq_group0_line0_o(pin_irq_group0_line0_o),
    .pin_irq_group0_line1_o(pin_irq_group0_line1_o));
